/* brake_thermal.sv */
`include "limiter_consts.svh"
// Leaky-bucket heat model of braking resistor
module brake_thermal #(
   parameter int tick_cycles = `THERM_TICK_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic braking,
   input wire logic [15:0] brake_power,
   input wire logic [13:0] discharge_capability,
   input wire logic [16:0] allowable_average_loss,
   output logic overheat
);
   logic [31:0] heat;
   logic [31:0] next_heat;
   logic [$clog2(tick_cycles+1)-1:0] tick_cnt;
   wire tick = (tick_cnt == '0);
   // Heat in units of power-ticks; loss removed each tick, capacity in same scale
   wire [31:0] gain = braking ? {16'h0000, brake_power} : 32'h0000_0000;
   // Loss comes in 0.001 kW steps so the smallest setting stays reachable
   wire [31:0] loss = {15'h0000, allowable_average_loss};
   wire [31:0] limit = {discharge_capability, 10'h000} * 32'h0000_0001;
   wire disabled = (discharge_capability == `DISCHARGE_OFF);
   assign next_heat = disabled ? 32'h0000_0000 :
                      !tick ? heat :
                      (heat + gain > loss) ? heat + gain - loss : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt <= '0;
         heat <= 32'h0000_0000;
         overheat <= 1'b0;
      end else begin
         tick_cnt <= tick ? ($bits(tick_cnt))'(tick_cycles - 1) : tick_cnt - 1'b1;
         heat <= next_heat;
         overheat <= !disabled && (next_heat > limit); // [R10] [R12]
      end
   end
endmodule

/* current_limiter.sv */
// Notes on behaviour
// R1: Overcurrent above level pulls output frequency down
// R2: Limiter level resets to 130 percent
// R3: Mode gates limiter by running state
// R4: Level held within 20 to 150 percent
// R5: Instant mode picks trip or limiting
// R6: Instant limiting blanks gate, frequency continues
// R7: Sensor vector control: no limiting, trip
// R8: Software avoids torque and current limiter together
// R9: Software picks trip where torque drop hazardous
// R10: Discharge 1 to 9000, zero disables protection
// R11: Average loss held within 0.001 to 99.99
// R12: Modelled heat over limit raises overheat alarm
// R13: Resistance zero selects legacy method
// R14: Software derives discharge capability
// R15: Software derives allowable average loss
// R16: Temperature switch wired to external alarm input
// R17: Resistance held within 0.01 to 999 ohm
// R18: Running state from frequency versus target
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`include "limiter_consts.svh"
module current_limiter import limiter_pkg::*; #(
   parameter int therm_tick_cycles = `THERM_TICK_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire drive_in_t drive_in,
   input wire logic braking,
   input wire logic [15:0] brake_power,
   input wire logic external_alarm_input,
   output drive_out_t drive_out,
   output logic irq
);
   // Software state
   limiter_mode_t limiter_mode_select;
   logic instant_overcurrent_mode;
   logic sensor_vector_control;
   logic duty_rating_select;
   logic [7:0] limiter_level;
   logic [13:0] discharge_capability;
   logic [16:0] allowable_average_loss;
   logic [16:0] braking_resistance;
   logic [`EV_COUNT-1:0] status;
   logic [`EV_COUNT-1:0] irq_enable;

   // AHB address phase capture
   logic wr_pending;
   logic [11:0] wr_addr;
   wire take = hsel && hready && htrans[1];
   wire take_rd = take && !hwrite;

   // Write decode, data phase
   wire wr_ctl = wr_pending && wr_addr == `OFS_CONTROL;
   wire wr_lvl = wr_pending && wr_addr == `OFS_LEVEL;
   wire wr_dis = wr_pending && wr_addr == `OFS_DISCHARGE;
   wire wr_avg = wr_pending && wr_addr == `OFS_AVG_LOSS;
   wire wr_res = wr_pending && wr_addr == `OFS_RESISTANCE;
   wire wr_ien = wr_pending && wr_addr == `OFS_IRQ_ENABLE;
   wire wr_clr = wr_pending && wr_addr == `OFS_IRQ_CLEAR;

   // Clamp written values into legal ranges
   wire [7:0] lvl_in = hwdata[7:0];
   wire [7:0] lvl_clamped = (hwdata[31:8] != '0 || lvl_in > `LEVEL_MAX) ? `LEVEL_MAX :
                            (lvl_in < `LEVEL_MIN) ? `LEVEL_MIN : lvl_in; // [R4]
   wire [13:0] dis_clamped = (hwdata[31:14] != '0 || hwdata[13:0] > `DISCHARGE_MAX) ?
                             `DISCHARGE_MAX : hwdata[13:0]; // [R10]
   wire [16:0] avg_clamped = (hwdata[31:17] != '0 || hwdata[16:0] > `AVG_LOSS_MAX) ? `AVG_LOSS_MAX :
                             (hwdata[16:0] < `AVG_LOSS_MIN) ? `AVG_LOSS_MIN : hwdata[16:0]; // [R11]
   // Zero kept as the legacy selector, otherwise 0.01 ohm units up to 999
   wire [16:0] res_clamped = (hwdata[31:17] != '0 || hwdata[16:0] > `RES_MAX) ?
                             `RES_MAX : hwdata[16:0]; // [R13] [R17]
   wire [1:0] mode_in = hwdata[`CTL_MODE_LSB+1:`CTL_MODE_LSB];
   wire limiter_mode_t mode_next = (mode_in == 2'd3) ? mode_off : limiter_mode_t'(mode_in);

   // Rated current follows duty selection; level scaled to current units
   wire [15:0] rated = duty_rating_select ? `RATED_NORMAL : `RATED_HEAVY;
   wire [23:0] level_amps_w = 24'(rated) * 24'(limiter_level);
   wire [15:0] level_amps = level_amps_w[15:0];

   // Running state and limiter gate
   run_state_t run_state;
   wire gate_by_state = (limiter_mode_select == mode_accel_const && run_state != run_decel) ||
                        (limiter_mode_select == mode_const && run_state == run_const); // [R3]
   wire over_level = drive_in.output_current > level_amps;
   wire soft_limit = gate_by_state && over_level && !sensor_vector_control; // [R1] [R7]
   wire at_instant = drive_in.output_current >= drive_in.instant_level;
   wire instant_limit = at_instant && instant_overcurrent_mode && !sensor_vector_control; // [R5] [R6]
   wire instant_trip = at_instant && (!instant_overcurrent_mode || sensor_vector_control); // [R5] [R7]
   wire pull_down = soft_limit || instant_limit;

   logic [15:0] output_freq;
   logic overheat;

   // Frequency keeps being steered even while the gate is blanked [R6]
   freq_ramp #(
      .width(16)
   ) u_ramp (
      .hclk(hclk),
      .hresetn(hresetn),
      .target_freq(drive_in.target_freq),
      .pull_down(pull_down),
      .output_freq(output_freq),
      .run_state(run_state)
   );

   brake_thermal #(
      .tick_cycles(therm_tick_cycles)
   ) u_thermal (
      .hclk(hclk),
      .hresetn(hresetn),
      .braking(braking),
      .brake_power(brake_power),
      .discharge_capability(discharge_capability),
      .allowable_average_loss(allowable_average_loss),
      .overheat(overheat)
   );

   // Event sources; set wins over software clear
   wire [`EV_COUNT-1:0] events = {external_alarm_input, overheat, instant_trip, instant_limit, soft_limit};
   wire [`EV_COUNT-1:0] clr_mask = wr_clr ? hwdata[`EV_COUNT-1:0] : '0;
   wire [`EV_COUNT-1:0] next_status = (status & ~clr_mask) | events;
   wire next_irq = |(next_status & (wr_ien ? hwdata[`EV_COUNT-1:0] : irq_enable));

   // Read mux, unmapped addresses read zero
   logic [31:0] rd_word;
   always_comb begin
      case (haddr)
         `OFS_CONTROL: rd_word = {27'h0, duty_rating_select, sensor_vector_control,
                                  instant_overcurrent_mode, limiter_mode_select};
         `OFS_LEVEL: rd_word = {24'h0, limiter_level};
         `OFS_DISCHARGE: rd_word = {18'h0, discharge_capability};
         `OFS_AVG_LOSS: rd_word = {15'h0, allowable_average_loss};
         `OFS_RESISTANCE: rd_word = {15'h0, braking_resistance};
         `OFS_STATUS: rd_word = {27'h0, status};
         `OFS_IRQ_ENABLE: rd_word = {27'h0, irq_enable};
         `OFS_INPUTS: rd_word = {14'h0, run_state, output_freq};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Bus phase tracking; slave is always ready with zero waits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_addr <= 12'h000;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pending <= take && hwrite;
         wr_addr <= haddr;
         hrdata <= take_rd ? rd_word : hrdata; // Read word registered at address phase
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         limiter_mode_select <= mode_off;
         instant_overcurrent_mode <= 1'b0;
         sensor_vector_control <= 1'b0;
         duty_rating_select <= 1'b0;
         limiter_level <= `LEVEL_RESET; // [R2]
      end else begin
         if (wr_ctl) begin
            limiter_mode_select <= mode_next;
            instant_overcurrent_mode <= hwdata[`CTL_INSTANT_BIT];
            sensor_vector_control <= hwdata[`CTL_SENSOR_BIT];
            duty_rating_select <= hwdata[`CTL_DUTY_BIT];
         end
         if (wr_lvl) begin
            limiter_level <= lvl_clamped;
         end
      end
   end

   // Resistor protection settings; discharge resets to off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         discharge_capability <= `DISCHARGE_OFF;
         allowable_average_loss <= `AVG_LOSS_MIN;
         braking_resistance <= 17'h0_0000;
      end else begin
         discharge_capability <= wr_dis ? dis_clamped : discharge_capability;
         allowable_average_loss <= wr_avg ? avg_clamped : allowable_average_loss;
         braking_resistance <= wr_res ? res_clamped : braking_resistance;
      end
   end

   // Events, interrupt and drive outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= '0;
         irq_enable <= '0;
         irq <= 1'b0;
         drive_out <= '0;
      end else begin
         status <= next_status; // [R12]
         irq_enable <= wr_ien ? hwdata[`EV_COUNT-1:0] : irq_enable;
         irq <= next_irq;
         drive_out.output_freq <= output_freq;
         drive_out.gate_enable <= !instant_limit && !instant_trip; // [R6]
         drive_out.overcurrent_trip <= instant_trip; // [R5] [R7]
         drive_out.resistor_overheat <= overheat; // [R12]
         drive_out.limiting <= pull_down;
      end
   end
endmodule

/* freq_ramp.sv */
`include "limiter_consts.svh"
// Steps output frequency toward target, or down while pulling current back
module freq_ramp import limiter_pkg::*; #(
   parameter int width = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [width-1:0] target_freq,
   input wire logic pull_down,
   output logic [width-1:0] output_freq,
   output run_state_t run_state
);
   logic [width-1:0] next_freq;
   wire at_target = (output_freq == target_freq);
   wire go_up = (output_freq < target_freq) && !pull_down;
   wire go_down = (output_freq > target_freq) || (pull_down && output_freq != '0);
   // Classification of running state, from freq against target [R18]
   wire run_state_t next_state = at_target ? run_const : (output_freq < target_freq ? run_accel : run_decel);
   assign next_freq = go_up ? output_freq + width'(`FREQ_STEP) :
                      go_down ? output_freq - width'(`FREQ_STEP) : output_freq;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_freq <= '0;
         run_state <= run_const;
      end else begin
         output_freq <= next_freq;
         run_state <= next_state;
      end
   end
endmodule

/* limiter_chk.sv */
module limiter_chk import limiter_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire drive_in_t drive_in,
   input wire drive_out_t drive_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Windows of three cycles, four for the deceleration check, absorb the registered output lag
   wire logic over = drive_in.output_current >= drive_in.instant_level;
   wire logic [15:0] freq = drive_out.output_freq;
   AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait OKAY");
   AST_UNMAPPED_READ: assert property (hsel && hready && htrans[1] && !hwrite && haddr > 12'h023
      |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
   AST_OVER_ACTS: assert property (over |=> !drive_out.gate_enable || drive_out.overcurrent_trip)
      else $error("instant level reached without blanking or trip");
   AST_UNDER_QUIET: assert property (!over [*3] |-> drive_out.gate_enable && !drive_out.overcurrent_trip)
      else $error("gate off or trip below instant level");
   AST_FREQ_STEP: assert property (freq == $past(freq) || freq == $past(freq) + 16'h0001
      || freq == $past(freq) - 16'h0001) else $error("frequency stepped by more than one");
   AST_LIMIT_DOWN: assert property (drive_out.limiting [*3] ##0 freq > 16'h0002
      |=> freq < $past(freq, 3)) else $error("limiting did not pull frequency down");
   AST_LIMIT_FLOOR: assert property ((drive_in.output_current < 16'h07d0) [*3] |-> !drive_out.limiting)
      else $error("limiting below the lowest possible level");
   AST_NO_DECEL_LIMIT: assert property ((freq > drive_in.target_freq) [*4] |-> !drive_out.limiting)
      else $error("limiting while decelerating");
endmodule
bind current_limiter limiter_chk u_chk(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .drive_in(drive_in),
   .drive_out(drive_out));

/* limiter_consts.svh */
`ifndef LIMITER_CONSTS_SVH
`define LIMITER_CONSTS_SVH
// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_LEVEL 12'h004
`define OFS_DISCHARGE 12'h008
`define OFS_AVG_LOSS 12'h00C
`define OFS_RESISTANCE 12'h010
`define OFS_STATUS 12'h014
`define OFS_IRQ_ENABLE 12'h018
`define OFS_IRQ_CLEAR 12'h01C
`define OFS_INPUTS 12'h020
// Control fields
`define CTL_MODE_LSB 0
`define CTL_INSTANT_BIT 2
`define CTL_SENSOR_BIT 3
`define CTL_DUTY_BIT 4
// Status / event bits
`define EV_LIMIT 0
`define EV_GATE_OFF 1
`define EV_OC_TRIP 2
`define EV_BR_OVERHEAT 3
`define EV_EXT_ALARM 4
`define EV_COUNT 5
// Reset values and ranges
// Level in percent of rated current: 130, 20 and 150
`define LEVEL_RESET 8'h82
`define LEVEL_MIN 8'h14
`define LEVEL_MAX 8'h96
// Discharge in kWs, zero means protection off; 9000 at most
`define DISCHARGE_OFF 14'h0000
`define DISCHARGE_MAX 14'h2328
// Average loss in 0.001 kW steps, 1 to 99990
`define AVG_LOSS_MIN 17'h0_0001
`define AVG_LOSS_MAX 17'h1_8696
// Resistance in 0.01 ohm steps, 99900 at most
`define RES_MAX 17'h1_863c
// Rated current units for heavy (100) and normal (120) duty
`define RATED_HEAVY 16'h0064
`define RATED_NORMAL 16'h0078
// Frequency step per cycle, toward target or pulling down, and tick time
`define FREQ_STEP 16'h0001
`define THERM_TICK_NS 1000000
`define CLK_NS 100
`define THERM_TICK_CYC ((`THERM_TICK_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* limiter_pkg.sv */
package limiter_pkg;
   typedef enum logic [1:0] {
      mode_off = 2'd0,
      mode_const = 2'd1,
      mode_accel_const = 2'd2
   } limiter_mode_t;
   typedef enum logic [1:0] {
      run_const = 2'b00,
      run_accel = 2'b01,
      run_decel = 2'b11
   } run_state_t;
   typedef struct packed {
      logic [15:0] output_current;
      logic [15:0] instant_level;
      logic [15:0] target_freq;
   } drive_in_t;
   typedef struct packed {
      logic [15:0] output_freq;
      logic gate_enable;
      logic overcurrent_trip;
      logic resistor_overheat;
      logic limiting;
   } drive_out_t;
endpackage

/* motor_model.sv */
// Far side: motor current follows the gate, resistor heat and its switch
module motor_model (
   input wire logic hclk,
   input wire logic gate_enable,
   input wire logic [15:0] load,
   input wire logic [15:0] brake_kw,
   input wire logic hot,
   output logic [15:0] output_current,
   output logic braking,
   output logic [15:0] brake_power,
   output logic external_alarm_input
);
   // Blanked gate collapses winding current one cycle later
   always_ff @(posedge hclk) output_current <= gate_enable ? load : 16'h0000;
   // Regenerated power only while braking
   assign braking = brake_kw != 16'h0000;
   assign brake_power = brake_kw;
   // Resistor temperature switch wired to the alarm input
   assign external_alarm_input = hot;
endmodule

/* tb_output_current_limiter.sv */
`include "limiter_consts.svh"
module tb_output_current_limiter import limiter_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hot = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [11:0] haddr = 12'h000;
   logic [31:0] hwdata = 32'h0000_0000, rd, hrdata, lfsr_state = 32'h0000_b8ae;
   logic [15:0] tgt = 16'h0000, inst = 16'hf000, load = 16'h0000, brake_kw = 16'h0000, cur, brake_power;
   logic hreadyout, hresp, irq, braking, alarm;
   drive_in_t drive_in;
   drive_out_t drive_out;
   int fails = 0, checked = 0, cyc = 0;
   // Clamp table: address, written, read back
   logic [11:0] ta [7] = '{`OFS_LEVEL, `OFS_LEVEL, `OFS_DISCHARGE, `OFS_AVG_LOSS, `OFS_AVG_LOSS, `OFS_RESISTANCE,
      `OFS_RESISTANCE};
   logic [31:0] tw [7] = '{32'h0000_000a, 32'h0000_00c8, 32'h0000_251c, 32'h0000_0000, 32'h0001_86a0,
      32'h0001_86a0, 32'h0000_0000};
   logic [31:0] tx [7] = '{32'h0000_0014, 32'h0000_0096, 32'h0000_2328, 32'h0000_0001, 32'h0001_8696,
      32'h0001_863c, 32'h0000_0000};
   // Instant cases: control, status mask, expected status
   logic [31:0] ic [4] = '{32'h0000_0006, 32'h0000_0002, 32'h0000_000e, 32'h0000_0012};
   logic [31:0] im [4] = '{32'h0000_0006, 32'h0000_0006, 32'h0000_0007, 32'h0000_0001};
   logic [31:0] ie [4] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0004, 32'h0000_0000};
   assign drive_in = {cur, inst, tgt};
   current_limiter #(.therm_tick_cycles(4)) u_dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .drive_in(drive_in), .braking(braking), .brake_power(brake_power),
      .external_alarm_input(alarm), .drive_out(drive_out), .irq(irq));
   motor_model u_far(.hclk(hclk), .gate_enable(drive_out.gate_enable), .load(load), .brake_kw(brake_kw), .hot(hot),
      .output_current(cur), .braking(braking), .brake_power(brake_power), .external_alarm_input(alarm));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] clamp(input logic [7:0] v);
      return v < 8'h14 ? 32'h0000_0014 : v > 8'h96 ? 32'h0000_0096 : {24'h00_0000, v};
   endfunction
   // Limiter active: mode 1 at constant speed, mode 2 unless decelerating
   function automatic logic [31:0] exp_limit(input int m, input int s);
      return {31'h0000_0000, (m == 2 && s != 2) || (m == 1 && s == 0)};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Single word transfer; request held until hready seen high
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask
   task automatic settle(input logic [15:0] t);
      tgt <= t;
      do @(posedge hclk); while (drive_out.output_freq !== t);
      repeat (3) @(posedge hclk);
   endtask
   // Steady at 200, then load of 6000 under a new target; torque limiter never in use
   task automatic stim(input logic [31:0] ctrl, input logic [15:0] t);
      bus(1'b1, `OFS_CONTROL, ctrl);
      settle(16'h00c8);
      rdchk(`OFS_INPUTS, 32'h0000_00c8);
      bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_001f);
      tgt <= t;
      load <= 16'h1770;
      repeat (8) @(posedge hclk);
      load <= 16'h0000;
      bus(1'b0, `OFS_STATUS, 32'h0000_0000);
   endtask
   task automatic tally_and_finish();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      forever #50 hclk = ~hclk;
   end
   // Hang guard well above the expected run
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(`OFS_LEVEL, 32'h0000_0082);
      rdchk(12'h040, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, ta[i], tw[i]);
         rdchk(ta[i], tx[i]);
      end
      repeat (4) begin
         lfsr_state = lfsr(lfsr_state);
         bus(1'b1, `OFS_LEVEL, {24'h00_0000, lfsr_state[7:0]});
         rdchk(`OFS_LEVEL, clamp(lfsr_state[7:0]));
      end
      // Level 50 on heavy rating gives a threshold of 5000
      bus(1'b1, `OFS_LEVEL, 32'h0000_0032);
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 3; s++) begin
            stim(32'(m), s == 0 ? 16'h00c8 : s == 1 ? 16'h0190 : 16'h0000);
            check(rd & 32'h0000_0001, exp_limit(m, s));
         end
      end
      // Instant level 5500 under the 6000 load; trip is the safe choice
      inst <= 16'h157c;
      for (int i = 0; i < 4; i++) begin
         stim(ic[i], 16'h00c8);
         check(rd & im[i], ie[i]);
      end
      inst <= 16'hf000;
      bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_001f);
      bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0010);
      hot <= 1'b1;
      repeat (3) @(posedge hclk);
      hot <= 1'b0;
      check(32'(irq), 32'h0000_0001);
      bus(1'b1, `OFS_STATUS, 32'h0000_0000);
      bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0000);
      rdchk(`OFS_STATUS, 32'h0000_0010);
      check(32'(irq), 32'h0000_0000);
      bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0010);
      repeat (2) @(posedge hclk);
      check(32'(irq), 32'h0000_0001);
      bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_0010);
      repeat (2) @(posedge hclk);
      check(32'(irq), 32'h0000_0000);
      // Small resistor: capability from time and capacity loss from duty
      bus(1'b1, `OFS_DISCHARGE, 32'h0000_0001);
      bus(1'b1, `OFS_AVG_LOSS, 32'h0000_0001);
      brake_kw <= 16'h00c8;
      repeat (60) @(posedge hclk);
      check(32'(drive_out.resistor_overheat), 32'h0000_0001);
      rdchk(`OFS_STATUS, 32'h0000_0008);
      bus(1'b1, `OFS_DISCHARGE, 32'h0000_0000);
      repeat (5) @(posedge hclk);
      check(32'(drive_out.resistor_overheat), 32'h0000_0000);
      brake_kw <= 16'h0000;
      tally_and_finish();
   end
endmodule
